// ### rtl/osr_defines.svh
`ifndef OSR_DEFINES_SVH
`define OSR_DEFINES_SVH

`define OSR_ADDR_MODE 12'h214
`define OSR_ADDR_PSEL 12'h215
`define OSR_ADDR_SYNC 12'h219
`define OSR_ADDR_STAT 12'h21A
`define OSR_ADDR_SPIN 12'h297

// Frequency banks: 16 bytes each, page is addr[11:4]
`define OSR_FREQ_A_PAGE 8'h22
`define OSR_FREQ_B_PAGE 8'h23
// Phase banks: 8 bytes each, page is addr[11:3]
`define OSR_PHASE_A_PAGE 9'h048
`define OSR_PHASE_B_PAGE 9'h049

`define OSR_SYNC_RST 8'h02
`define OSR_SYNC_ILA_BIT 1
`define OSR_SYNC_ARM_BIT 0
`define OSR_MODE_RST 8'h00
`define OSR_PSEL_RST 8'h00
`define OSR_PSEL_A_LSB 0
`define OSR_PSEL_B_LSB 2
`define OSR_FREQ_RST 32'hC000_0000
`define OSR_PHASE_RST 16'h0000
`define OSR_PHASE_PAD 16'h0000

`define OSR_MODE_PSEL_REG 2'h0
`define OSR_MODE_PINS_EACH 2'h1
`define OSR_MODE_PINS_A 2'h2

// Arbitrary value, not tied to any product
`define OSR_REV_ID_DEFAULT 8'h03

`endif

// ### rtl/osr_nco_path.sv
`timescale 1ns/1ps
`include "osr_defines.svh"

module osr_nco_path
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire osr_pkg::osr_word_t freq_word,
  input wire osr_pkg::osr_half_t phase_off,
  input wire logic load,
  output osr_pkg::osr_word_t phase_out
);
  import osr_pkg::*;

  typedef struct packed
  {
    osr_word_t acc;
    osr_word_t phase;
  } osr_path_s;

  osr_path_s q;
  osr_path_s d;

  always_comb
  begin
    d = q;
    if (load)
    begin
      d.acc = '0;
    end
    else
    begin
      d.acc = q.acc + freq_word;
    end
    d.phase = d.acc + {phase_off, `OSR_PHASE_PAD};
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign phase_out = q.phase;

  property p_acc_step;
    @(posedge sys_clk) disable iff (!rst_n)
    !load |=> q.acc == $past(q.acc) + $past(freq_word);
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

  property p_off_justify;
    @(posedge sys_clk) disable iff (!rst_n)
    load |=> phase_out == {$past(phase_off), `OSR_PHASE_PAD};
  endproperty
  a_off_justify: assert property (p_off_justify) else $error("offset not msb justified");

endmodule

// ### rtl/osr_pkg.sv
package osr_pkg;

  typedef logic [11:0] osr_addr_t;
  typedef logic [7:0] osr_byte_t;
  typedef logic [31:0] osr_word_t;
  typedef logic [15:0] osr_half_t;
  typedef logic [1:0] osr_sel_t;

  typedef enum logic
  {
    OSR_ARM_IDLE = 1'b0,
    OSR_ARM_WAIT = 1'b1
  } osr_arm_e;

endpackage

// ### rtl/osr_regs.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "osr_defines.svh"

// Function
// - With link select set, load phase on the alignment-start multiframe edge.
// - Writing arm bit zero then one arms loading on next sysref rise.
// - After a sysref load, further sysref edges are ignored until re-armed.
// - Controller pulses sysref; device loads phase on the first rising edge.
// - Phase offset sits in the upper half of a 32-bit word, added in.
// - Phase offsets are stored raw, valid as signed or unsigned.
// - Sync control resets to link-edge loading with sysref arming inactive.
// - A read-only revision register returns a fixed identification value.
// - In source mode zero, preset select fields choose each path's preset.
module osr_regs
#(
  parameter osr_pkg::osr_byte_t REV_ID = `OSR_REV_ID_DEFAULT
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire osr_pkg::osr_addr_t reg_addr,
  input wire osr_pkg::osr_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output osr_pkg::osr_byte_t reg_rdata,
  input wire logic sysref,
  input wire logic ila_lmfc_start,
  input wire osr_pkg::osr_sel_t preset_pins_a,
  input wire osr_pkg::osr_sel_t preset_pins_b,
  output osr_pkg::osr_word_t nco_phase_a,
  output osr_pkg::osr_word_t nco_phase_b,
  output logic phase_init_pulse
);
  import osr_pkg::*;

  typedef struct packed
  {
    osr_byte_t sync;
    osr_byte_t mode;
    osr_byte_t psel;
    logic [3:0][31:0] freq_a;
    logic [3:0][31:0] freq_b;
    logic [3:0][15:0] phase_a;
    logic [3:0][15:0] phase_b;
    osr_arm_e arm;
    logic sysref_prev;
    logic init_pulse;
    osr_byte_t rdata;
  } osr_state_s;

  osr_state_s q;
  osr_state_s d;

  logic sys_rise;
  logic ila_load;
  logic sr_load;
  logic phase_load;
  osr_sel_t sel_a;
  osr_sel_t sel_b;
  osr_word_t freq_act_a;
  osr_word_t freq_act_b;
  osr_half_t off_act_a;
  osr_half_t off_act_b;
  logic wr_freq_a;
  logic wr_freq_b;
  logic wr_phase_a;
  logic wr_phase_b;

  function automatic osr_word_t put_byte
  (
    input osr_word_t w,
    input logic [1:0] idx,
    input osr_byte_t b
  );
    osr_word_t r;
    r = w;
    r[idx*8 +: 8] = b;
    return r;
  endfunction

  function automatic osr_byte_t get_byte
  (
    input osr_word_t w,
    input logic [1:0] idx
  );
    return w[idx*8 +: 8];
  endfunction

  function automatic osr_sel_t pick_preset
  (
    input logic [1:0] mode,
    input osr_sel_t sel_reg,
    input osr_sel_t pins_own,
    input osr_sel_t pins_a
  );
    osr_sel_t r;
    case (mode)
      `OSR_MODE_PINS_EACH: r = pins_own;
      `OSR_MODE_PINS_A: r = pins_a;
      default: r = sel_reg;
    endcase
    return r;
  endfunction

  // Preset choice per path
  assign sel_a = pick_preset(q.mode[1:0], q.psel[`OSR_PSEL_A_LSB +: 2],
                             preset_pins_a, preset_pins_a);
  assign sel_b = pick_preset(q.mode[1:0], q.psel[`OSR_PSEL_B_LSB +: 2],
                             preset_pins_b, preset_pins_a);
  assign freq_act_a = q.freq_a[sel_a];
  assign freq_act_b = q.freq_b[sel_b];
  assign off_act_a = q.phase_a[sel_a];
  assign off_act_b = q.phase_b[sel_b];

  // Phase load sources
  assign sys_rise = sysref && !q.sysref_prev;
  assign ila_load = ila_lmfc_start && q.sync[`OSR_SYNC_ILA_BIT];
  assign sr_load = sys_rise && (q.arm == OSR_ARM_WAIT);
  assign phase_load = ila_load || sr_load;

  // Bank decode
  assign wr_freq_a = reg_wr && (reg_addr[11:4] == `OSR_FREQ_A_PAGE);
  assign wr_freq_b = reg_wr && (reg_addr[11:4] == `OSR_FREQ_B_PAGE);
  assign wr_phase_a = reg_wr && (reg_addr[11:3] == `OSR_PHASE_A_PAGE);
  assign wr_phase_b = reg_wr && (reg_addr[11:3] == `OSR_PHASE_B_PAGE);

  always_comb
  begin
    d = q;
    d.rdata = '0;
    d.sysref_prev = sysref;
    d.init_pulse = phase_load;
    if (sr_load)
    begin
      d.arm = OSR_ARM_IDLE;
    end
    if (reg_wr)
    begin
      case (reg_addr)
        `OSR_ADDR_SYNC:
        begin
          d.sync = reg_wdata;
          // Re-arm after sysref clear so a new arm wins
          if (!q.sync[`OSR_SYNC_ARM_BIT] && reg_wdata[`OSR_SYNC_ARM_BIT])
          begin
            d.arm = OSR_ARM_WAIT;
          end
        end
        `OSR_ADDR_MODE: d.mode = reg_wdata;
        `OSR_ADDR_PSEL: d.psel = reg_wdata;
        default: d.sync = q.sync;
      endcase
    end
    // Raw bit storage, no sign handling
    if (wr_freq_a)
    begin
      d.freq_a[reg_addr[3:2]] = put_byte(q.freq_a[reg_addr[3:2]],
                                         reg_addr[1:0], reg_wdata);
    end
    if (wr_freq_b)
    begin
      d.freq_b[reg_addr[3:2]] = put_byte(q.freq_b[reg_addr[3:2]],
                                         reg_addr[1:0], reg_wdata);
    end
    if (wr_phase_a)
    begin
      d.phase_a[reg_addr[2:1]] = 16'(put_byte({16'h0000, q.phase_a[reg_addr[2:1]]},
                                             {1'b0, reg_addr[0]}, reg_wdata));
    end
    if (wr_phase_b)
    begin
      d.phase_b[reg_addr[2:1]] = 16'(put_byte({16'h0000, q.phase_b[reg_addr[2:1]]},
                                             {1'b0, reg_addr[0]}, reg_wdata));
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `OSR_ADDR_SYNC: d.rdata = q.sync;
        `OSR_ADDR_MODE: d.rdata = q.mode;
        `OSR_ADDR_PSEL: d.rdata = q.psel;
        `OSR_ADDR_STAT: d.rdata = {7'h00, q.arm == OSR_ARM_WAIT};
        `OSR_ADDR_SPIN: d.rdata = REV_ID;
        default:
        begin
          if (reg_addr[11:4] == `OSR_FREQ_A_PAGE)
          begin
            d.rdata = get_byte(q.freq_a[reg_addr[3:2]], reg_addr[1:0]);
          end
          else if (reg_addr[11:4] == `OSR_FREQ_B_PAGE)
          begin
            d.rdata = get_byte(q.freq_b[reg_addr[3:2]], reg_addr[1:0]);
          end
          else if (reg_addr[11:3] == `OSR_PHASE_A_PAGE)
          begin
            d.rdata = get_byte({16'h0000, q.phase_a[reg_addr[2:1]]}, {1'b0, reg_addr[0]});
          end
          else if (reg_addr[11:3] == `OSR_PHASE_B_PAGE)
          begin
            d.rdata = get_byte({16'h0000, q.phase_b[reg_addr[2:1]]}, {1'b0, reg_addr[0]});
          end
          else
          begin
            d.rdata = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.sync <= `OSR_SYNC_RST;
      q.mode <= `OSR_MODE_RST;
      q.psel <= `OSR_PSEL_RST;
      q.freq_a <= {4{`OSR_FREQ_RST}};
      q.freq_b <= {4{`OSR_FREQ_RST}};
      q.phase_a <= {4{`OSR_PHASE_RST}};
      q.phase_b <= {4{`OSR_PHASE_RST}};
      q.arm <= OSR_ARM_IDLE;
      q.sysref_prev <= 1'b0;
      q.init_pulse <= 1'b0;
      q.rdata <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Frequency changes do not disturb the accumulator; relink is software's job
  osr_nco_path u_path_a
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .freq_word(freq_act_a),
    .phase_off(off_act_a),
    .load(phase_load),
    .phase_out(nco_phase_a)
  );

  osr_nco_path u_path_b
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .freq_word(freq_act_b),
    .phase_off(off_act_b),
    .load(phase_load),
    .phase_out(nco_phase_b)
  );

  assign reg_rdata = q.rdata;
  assign phase_init_pulse = q.init_pulse;

  property p_ila_load;
    @(posedge sys_clk) disable iff (!rst_n)
    (ila_lmfc_start && q.sync[`OSR_SYNC_ILA_BIT])
      |=> phase_init_pulse && (nco_phase_a == {$past(off_act_a), `OSR_PHASE_PAD});
  endproperty
  a_ila_load: assert property (p_ila_load) else $error("link edge did not load phase");

  property p_arm_set;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `OSR_ADDR_SYNC && !q.sync[`OSR_SYNC_ARM_BIT]
      && reg_wdata[`OSR_SYNC_ARM_BIT]) |=> q.arm == OSR_ARM_WAIT;
  endproperty
  a_arm_set: assert property (p_arm_set) else $error("zero-one write did not arm");

  property p_sysref_load;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.arm == OSR_ARM_WAIT && sysref && !q.sysref_prev)
      |=> phase_init_pulse && (nco_phase_b == {$past(off_act_b), `OSR_PHASE_PAD});
  endproperty
  a_sysref_load: assert property (p_sysref_load) else $error("armed sysref missed");

  property p_ignore_later;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.arm == OSR_ARM_IDLE && !(ila_lmfc_start && q.sync[`OSR_SYNC_ILA_BIT]))
      |=> !phase_init_pulse;
  endproperty
  a_ignore_later: assert property (p_ignore_later) else $error("unarmed sysref loaded");

  property p_disarm;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.arm == OSR_ARM_WAIT && sysref && !q.sysref_prev && !reg_wr)
      |=> q.arm == OSR_ARM_IDLE;
  endproperty
  a_disarm: assert property (p_disarm) else $error("arm not dropped after load");

  property p_freq_raw;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr[11:4] == `OSR_FREQ_A_PAGE)
      |=> get_byte(q.freq_a[$past(reg_addr[3:2])], $past(reg_addr[1:0])) == $past(reg_wdata);
  endproperty
  a_freq_raw: assert property (p_freq_raw) else $error("frequency byte altered");

  property p_phase_raw;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr[11:3] == `OSR_PHASE_B_PAGE && !reg_addr[0])
      |=> q.phase_b[$past(reg_addr[2:1])][7:0] == $past(reg_wdata);
  endproperty
  a_phase_raw: assert property (p_phase_raw) else $error("phase byte altered");

  property p_sync_reset;
    @(posedge sys_clk)
    $rose(rst_n) |-> (q.sync == `OSR_SYNC_RST) && (q.arm == OSR_ARM_IDLE);
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync reset value wrong");

  property p_spin_read;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `OSR_ADDR_SPIN) |=> reg_rdata == REV_ID ##1 reg_rdata == 8'h00
      || $past(reg_rd);
  endproperty
  a_spin_read: assert property (p_spin_read) else $error("revision read wrong");

  property p_reg_sel_mode;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.mode[1:0] == `OSR_MODE_PSEL_REG)
      |-> sel_a == q.psel[`OSR_PSEL_A_LSB +: 2] && sel_b == q.psel[`OSR_PSEL_B_LSB +: 2];
  endproperty
  a_reg_sel_mode: assert property (p_reg_sel_mode) else $error("preset select ignored");

  property p_ila_load_b;
    @(posedge sys_clk) disable iff (!rst_n)
    (ila_lmfc_start && q.sync[`OSR_SYNC_ILA_BIT])
      |=> nco_phase_b == {$past(off_act_b), `OSR_PHASE_PAD};
  endproperty
  a_ila_load_b: assert property (p_ila_load_b) else $error("link edge missed path b");

  property p_sysref_load_a;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.arm == OSR_ARM_WAIT && sysref && !q.sysref_prev)
      |=> nco_phase_a == {$past(off_act_a), `OSR_PHASE_PAD};
  endproperty
  a_sysref_load_a: assert property (p_sysref_load_a) else $error("path a not loaded");

  property p_arm_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.arm == OSR_ARM_IDLE && !(reg_wr && reg_addr == `OSR_ADDR_SYNC))
      |=> q.arm == OSR_ARM_IDLE;
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("arm set without sync write");

endmodule

// ### tb/osr_regs_tb_top.sv
`timescale 1ns/1ps
`include "osr_defines.svh"

module osr_regs_tb_top;
  import osr_pkg::*;
  // Arbitrary identification value
  localparam osr_byte_t SPIN_TB = 8'h5A;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  osr_addr_t reg_addr = '0;
  osr_byte_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  osr_byte_t reg_rdata;
  logic sysref;
  logic ila_lmfc_start;
  logic phase_init_pulse;
  logic sysref_req = 1'b0;
  logic ila_req = 1'b0;
  osr_sel_t preset_pins_a = 2'h3;
  osr_sel_t preset_pins_b = 2'h1;
  osr_word_t nco_phase_a;
  osr_word_t nco_phase_b;
  osr_word_t ph_a = '0;
  osr_word_t ph_b = '0;
  osr_word_t ph_a2 = '0;
  osr_word_t ph_b2 = '0;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int loads = 0;
  logic seen = 1'b0;

  always #5 sys_clk = ~sys_clk;

  osr_regs #(.REV_ID(SPIN_TB)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sysref(sysref), .ila_lmfc_start(ila_lmfc_start), .preset_pins_a(preset_pins_a),
    .preset_pins_b(preset_pins_b), .nco_phase_a(nco_phase_a), .nco_phase_b(nco_phase_b),
    .phase_init_pulse(phase_init_pulse));

  osr_sync_src #(.PULSE_LEN(2)) u_src (.sys_clk(sys_clk), .rst_n(rst_n),
    .sysref_req(sysref_req), .ila_req(ila_req), .sysref(sysref),
    .ila_lmfc_start(ila_lmfc_start));

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Captures phase at the load pulse and one cycle after
  always @(posedge sys_clk)
  begin
    cycles++;
    if (seen)
    begin
      ph_a2 = nco_phase_a;
      ph_b2 = nco_phase_b;
    end
    seen = (phase_init_pulse === 1'b1);
    if (seen)
    begin
      loads++;
      ph_a = nco_phase_a;
      ph_b = nco_phase_b;
    end
    if (cycles == 3000)
    begin
      failures++;
      $display("[FAIL] %0t run timed out", $time);
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input osr_addr_t a, input osr_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input osr_addr_t a, input osr_byte_t exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({24'h0, reg_rdata}, {24'h0, exp}, what);
  endtask

  task automatic wr_n(input osr_addr_t a, input osr_word_t v, input int n);
    for (int i = 0; i < n; i++)
      wr(osr_addr_t'(a + i), v[8*i +: 8]);
  endtask

  task automatic rd_n_chk(input osr_addr_t a, input osr_word_t v, input int n, input string what);
    for (int i = 0; i < n; i++)
      rd_chk(osr_addr_t'(a + i), v[8*i +: 8], what);
  endtask

  // Asks the far side for a SYSREF pulse or a multiframe edge, then lets it settle
  task automatic fire(input logic use_sysref);
    @(posedge sys_clk);
    sysref_req <= use_sysref;
    ila_req <= ~use_sysref;
    @(posedge sys_clk);
    sysref_req <= 1'b0;
    ila_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk_load(input int n, input osr_word_t a, input osr_word_t b,
                          input osr_word_t a2, input osr_word_t b2);
    chk(32'(loads), 32'(n), "load count");
    chk(ph_a, a, "path a loaded phase");
    chk(ph_b, b, "path b loaded phase");
    chk(ph_a2, a2, "path a next phase");
    chk(ph_b2, b2, "path b next phase");
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(`OSR_ADDR_SYNC, 8'h02, "sync reset");
    rd_chk(`OSR_ADDR_SPIN, SPIN_TB, "revision id");
    wr(`OSR_ADDR_SPIN, 8'hFF);
    rd_chk(`OSR_ADDR_SPIN, SPIN_TB, "spin read only");
    rd_chk(12'h2FF, 8'h00, "unmapped read");
    rd_n_chk(12'h220, 32'hC000_0000, 4, "freq reset");
    // Frequencies are set before any phase load
    wr(`OSR_ADDR_MODE, 8'h00);
    wr(`OSR_ADDR_PSEL, 8'h06);
    wr_n(12'h228, 32'h8000_0001, 4);
    wr_n(12'h244, 32'h0000_8001, 2);
    wr_n(12'h234, 32'h0000_1234, 4);
    wr_n(12'h24A, 32'h0000_4000, 2);
    rd_n_chk(12'h228, 32'h8000_0001, 4, "freq a2");
    rd_n_chk(12'h244, 32'h0000_8001, 2, "phase a2");
    fire(1'b0);
    chk_load(1, 32'h8001_0000, 32'h4000_0000, 32'h0001_0001, 32'h4000_1234);
    wr(`OSR_ADDR_SYNC, 8'h00);
    wr(`OSR_ADDR_SYNC, 8'h01);
    rd_chk(`OSR_ADDR_STAT, 8'h01, "armed");
    fire(1'b0);
    chk(32'(loads), 32'h0000_0001, "edge ignored when deselected");
    fire(1'b1);
    chk_load(2, 32'h8001_0000, 32'h4000_0000, 32'h0001_0001, 32'h4000_1234);
    rd_chk(`OSR_ADDR_STAT, 8'h00, "disarmed");
    fire(1'b1);
    chk(32'(loads), 32'h0000_0002, "later sysref ignored");
    wr(`OSR_ADDR_SYNC, 8'h01);
    fire(1'b1);
    chk(32'(loads), 32'h0000_0002, "rewrite of one does not arm");
    wr(`OSR_ADDR_PSEL, 8'h00);
    wr(`OSR_ADDR_SYNC, 8'h00);
    wr(`OSR_ADDR_SYNC, 8'h01);
    fire(1'b1);
    chk_load(3, 32'h0000_0000, 32'h0000_0000, 32'hC000_0000, 32'hC000_0000);
    // Pin source per path: A on pins 3, B on pins 1
    wr(`OSR_ADDR_MODE, 8'h01);
    wr(`OSR_ADDR_SYNC, 8'h00);
    wr(`OSR_ADDR_SYNC, 8'h01);
    fire(1'b1);
    chk_load(4, 32'h0000_0000, 32'h4000_0000, 32'hC000_0000, 32'h4000_1234);
    // Path A pins drive both paths
    @(posedge sys_clk);
    preset_pins_a <= 2'h1;
    preset_pins_b <= 2'h3;
    wr(`OSR_ADDR_MODE, 8'h02);
    wr(`OSR_ADDR_SYNC, 8'h00);
    wr(`OSR_ADDR_SYNC, 8'h01);
    fire(1'b1);
    chk_load(5, 32'h0000_0000, 32'h4000_0000, 32'hC000_0000, 32'h4000_1234);
    // Reserved source mode falls back to register select
    wr(`OSR_ADDR_MODE, 8'h03);
    wr(`OSR_ADDR_SYNC, 8'h00);
    wr(`OSR_ADDR_SYNC, 8'h01);
    fire(1'b1);
    chk_load(6, 32'h0000_0000, 32'h0000_0000, 32'hC000_0000, 32'hC000_0000);
    final_report();
  end
endmodule

// ### tb/osr_sync_src.sv
`timescale 1ns/1ps

// Far-side model: SYSREF pulse source and lane-alignment multiframe edge source
module osr_sync_src
#(
  parameter int PULSE_LEN = 2
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sysref_req,
  input wire logic ila_req,
  output logic sysref,
  output logic ila_lmfc_start
);
  logic [3:0] cnt_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      sysref <= 1'b0;
      ila_lmfc_start <= 1'b0;
    end
    else
    begin
      ila_lmfc_start <= ila_req;
      if (sysref_req)
        cnt_q <= 4'(PULSE_LEN);
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 4'h1;
      sysref <= (cnt_q != 0);
    end
  end
endmodule
